// >>> include/dfc_pkg.sv
// Shared constants and carriers for the channel function setup block
package dfc_pkg;
    localparam int CODE_W = 10;
    localparam int CNT_W = 21;
    localparam logic [7:0] FUNC_SETUP_ADDR = 8'h12;
    localparam logic [15:0] FUNC_SETUP_RST = 16'h0000;
    localparam logic [CODE_W-1:0] ZERO_CODE = 10'h000;
    localparam logic [CODE_W-1:0] MID_CODE = 10'h200;
    localparam logic [CODE_W-1:0] ONE_CODE = 10'h001;
    // 0.03125 of the code is a right shift by five
    localparam int LOG_SHIFT = 5;
    localparam int QUARTER_SHIFT = 2;
    localparam logic [CODE_W:0] THIRD_DIV = 11'h003;
    localparam logic [2:0] WAVE_TRI = 3'h0;
    localparam logic [2:0] WAVE_SAW = 3'h1;
    localparam logic [2:0] WAVE_INV = 3'h2;
    localparam logic [2:0] WAVE_SINE = 3'h4;
    localparam logic [2:0] WAVE_OFF = 3'h7;
    localparam logic [1:0] PH_0 = 2'h0;
    localparam logic [1:0] PH_120 = 2'h1;
    localparam logic [1:0] PH_240 = 2'h2;
    localparam logic [1:0] PH_90 = 2'h3;
    localparam logic [3:0] SLEW_NONE = 4'h0;
    localparam logic [5:0] LIN_INC [8] = '{6'h01, 6'h02, 6'h03, 6'h04,
                                           6'h06, 6'h08, 6'h10, 6'h20};
    localparam real CLK_NS = 5.0;
    localparam real LIN_US [16] = '{0.0, 4.0, 8.0, 12.0, 18.0, 27.04, 40.0, 60.72,
                                    91.12, 136.72, 276.0, 418.64, 732.56, 1282.0,
                                    2563.96, 5127.92};
    localparam real LOG_US [8] = '{4.0, 12.0, 27.04, 60.72, 136.72, 418.64,
                                   1282.0, 5127.92};

    typedef logic [CNT_W-1:0] dfc_cnt_t;
    typedef dfc_cnt_t dfc_lin_t [16];
    typedef dfc_cnt_t dfc_log_t [8];
    typedef enum logic [1:0] {MODE_IDLE, MODE_MARGIN, MODE_WAVE} dfc_mode_e;
    typedef struct packed {
        logic [1:0] phase;
        logic [2:0] wave;
        logic log_en;
        logic [2:0] hi;
        logic [3:0] lo;
    } dfc_gen_s;
    typedef struct packed {
        logic clr_sel;
        logic defer;
        logic group;
        dfc_gen_s gen;
    } dfc_cfg_s;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } dfc_reg_req_s;
    typedef struct packed {
        logic valid;
        logic bcast;
        logic [CODE_W-1:0] code;
    } dfc_code_wr_s;
    typedef struct packed {
        logic go;
        logic high;
    } dfc_margin_s;

    function automatic dfc_cnt_t us2cyc(input real us);
        real c;
        c = us * 1000.0 / CLK_NS;
        return (c < 1.0) ? dfc_cnt_t'(1) : dfc_cnt_t'($rtoi(c + 0.5));
    endfunction
    function automatic dfc_lin_t lin_tab();
        dfc_lin_t t;
        for (int i = 0; i < 16; i++) t[i] = us2cyc(LIN_US[i]);
        return t;
    endfunction
    function automatic dfc_log_t log_tab();
        dfc_log_t t;
        for (int i = 0; i < 8; i++) t[i] = us2cyc(LOG_US[i]);
        return t;
    endfunction
endpackage

// >>> src/dfc_channel_func.sv
`timescale 1ns/1ps
// Channel function setup register with clear, update, margin ramp and waveform logic
// How it works
// [RQ1] Clear drives zero-scale when clear_level_select is 0, midscale when 1.
// [RQ2] Without deferral a written code reaches the output right after the write.
// [RQ3] With deferral the code waits for a load strobe falling edge or trigger.
// [RQ4] Broadcast code writes are taken only when group_write_accept is set.
// [RQ5] Phase field starts the waveform at 0, 120, 240 or 90 degrees.
// [RQ6] Waveform field: triangle, sawtooth, inverse sawtooth, sine, off; others invalid. Here sine runs the triangle path.
// [RQ7] Bit 7 picks linear or logarithmic ramp and reinterprets bits 6 to 0.
// [RQ8] Linear step size codes map to 1, 2, 3, 4, 6, 8, 16, 32 LSB.
// [RQ9] Linear interval 0000 makes margin moves jump; software avoids it for waveforms.
// [RQ10] Linear interval codes 0001 to 1111 space steps from 4 to 5127.92 us.
// [RQ11] Logarithmic ramp moves between the bounds in 3.125 percent steps.
// [RQ12] Upward logarithmic step grows the code by one thirty-second.
// [RQ13] Downward logarithmic step shrinks the code by one thirty-second.
// [RQ14] A zero lower bound starts the logarithmic ramp from code 1.
// [RQ15] Upward logarithmic ramp uses the upward interval, downward the downward one.
// [RQ16] Both logarithmic interval fields decode 4 to 5127.92 us identically.
// [RQ17] Intervals count the clock; rewriting setup or target restarts the count.
module dfc_channel_func
    import dfc_pkg::*;
#(
    parameter dfc_lin_t LIN_CYC = lin_tab(),
    parameter dfc_log_t LOG_CYC = log_tab()
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register access from the serial port decoder
    input wire dfc_reg_req_s reg_req,
    output logic [15:0] reg_rdata,
    // Channel code writes
    input wire dfc_code_wr_s code_wr,
    // Load, clear and margin controls
    input wire logic load_strobe_pin,
    input wire logic trig_load,
    input wire logic clear_req,
    input wire dfc_margin_s margin_req,
    input wire logic [CODE_W-1:0] lower_bound_code,
    input wire logic [CODE_W-1:0] upper_bound_code,
    // Channel output
    output logic [CODE_W-1:0] dac_code,
    output logic ramp_busy
);

    typedef struct packed {
        dfc_cfg_s cfg;
        dfc_mode_e mode;
        logic [CODE_W-1:0] code;
        logic [CODE_W-1:0] pend;
        logic pend_v;
        logic up;
        logic [CODE_W-1:0] target;
        dfc_cnt_t timer;
        logic [2:0] sync;
        logic lvl;
        logic [15:0] rdata;
        logic busy;
    } dfc_state_s;

    dfc_state_s s_ff;
    dfc_state_s nxt_s;
    logic cfg_wr;
    logic quiet;
    logic acc;
    logic ld;
    logic ld_go;
    logic mgo;
    logic tick;
    logic step;

    function automatic logic [CODE_W-1:0] sat_up(input logic [CODE_W-1:0] c,
                                                 input logic [CODE_W-1:0] a,
                                                 input logic [CODE_W-1:0] lim);
        logic [CODE_W:0] sum;
        sum = {1'b0, c} + {1'b0, a};
        return (sum >= {1'b0, lim}) ? lim : sum[CODE_W-1:0];
    endfunction

    function automatic logic [CODE_W-1:0] sat_dn(input logic [CODE_W-1:0] c,
                                                 input logic [CODE_W-1:0] a,
                                                 input logic [CODE_W-1:0] lim);
        return (c <= lim || (c - lim) <= a) ? lim : c - a;
    endfunction

    function automatic logic [CODE_W-1:0] log_amt(input logic [CODE_W-1:0] c);
        logic [CODE_W-1:0] q;
        q = c >> LOG_SHIFT; // [RQ12] [RQ13]
        // Small codes would stall at zero growth, so never step by less than one
        return (q == ZERO_CODE) ? ONE_CODE : q;
    endfunction

    function automatic logic [CODE_W-1:0] lin_amt(input logic [2:0] sel);
        return {4'h0, LIN_INC[sel]}; // [RQ8]
    endfunction

    function automatic dfc_cnt_t step_ival(input dfc_gen_s g, input logic up);
        if (!g.log_en) begin
            return LIN_CYC[g.lo]; // [RQ10]
        end
        return up ? LOG_CYC[g.hi] : LOG_CYC[g.lo[3:1]]; // [RQ15] [RQ16]
    endfunction

    function automatic logic wave_on(input dfc_gen_s g);
        // Invalid encodings and the zero interval leave the generator idle
        return !g.log_en && g.lo != SLEW_NONE &&
               (g.wave inside {WAVE_TRI, WAVE_SAW, WAVE_INV, WAVE_SINE}); // [RQ6] [RQ9]
    endfunction

    function automatic logic [CODE_W-1:0] phase_off(input logic [CODE_W-1:0] lo,
                                                    input logic [CODE_W-1:0] hi,
                                                    input logic [1:0] ph);
        logic [CODE_W:0] sp;
        logic [CODE_W:0] r;
        sp = (hi > lo) ? {1'b0, hi - lo} : {1'b0, ZERO_CODE};
        r = {1'b0, ZERO_CODE};
        unique case (ph)
            PH_0: r = {1'b0, ZERO_CODE};
            PH_120: r = sp / THIRD_DIV;
            PH_240: r = (sp << 1) / THIRD_DIV;
            PH_90: r = sp >> QUARTER_SHIFT;
        endcase
        return lo + r[CODE_W-1:0]; // [RQ5]
    endfunction

    assign cfg_wr = reg_req.wr && reg_req.addr == FUNC_SETUP_ADDR;
    assign quiet = !clear_req && !cfg_wr;
    assign acc = quiet && code_wr.valid && (!code_wr.bcast || s_ff.cfg.group); // [RQ4]
    // Falling edge only once the second and third stages agree on low
    assign ld = (s_ff.lvl && !s_ff.sync[1] && !s_ff.sync[2]) || trig_load; // [RQ3]
    assign ld_go = quiet && !acc && ld && s_ff.pend_v;
    assign mgo = quiet && !acc && !ld_go && margin_req.go;
    assign tick = (s_ff.timer == '0);
    assign step = quiet && !acc && !ld_go && !margin_req.go && tick;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.sync = {s_ff.sync[1:0], load_strobe_pin};
        if (s_ff.sync[2] == s_ff.sync[1]) begin
            nxt_s.lvl = s_ff.sync[2];
        end
        if (reg_req.rd) begin
            nxt_s.rdata = (reg_req.addr == FUNC_SETUP_ADDR) ? s_ff.cfg : 16'h0000;
        end
        nxt_s.timer = tick ? step_ival(s_ff.cfg.gen, s_ff.up) - dfc_cnt_t'(1)
                           : s_ff.timer - dfc_cnt_t'(1); // [RQ17]
        if (clear_req) begin
            nxt_s.code = s_ff.cfg.clr_sel ? MID_CODE : ZERO_CODE; // [RQ1]
            nxt_s.mode = MODE_IDLE;
            nxt_s.pend_v = 1'b0;
        end else if (cfg_wr) begin
            nxt_s.cfg = reg_req.wdata;
            nxt_s.up = 1'b1;
            nxt_s.timer = step_ival(nxt_s.cfg.gen, 1'b1) - dfc_cnt_t'(1); // [RQ17]
            if (wave_on(nxt_s.cfg.gen)) begin
                nxt_s.mode = MODE_WAVE;
                nxt_s.code = phase_off(lower_bound_code, upper_bound_code,
                                       nxt_s.cfg.gen.phase); // [RQ5]
            end else begin
                nxt_s.mode = MODE_IDLE; // [RQ6]
            end
        end else if (acc) begin
            if (s_ff.cfg.defer) begin
                nxt_s.pend = code_wr.code; // [RQ3]
                nxt_s.pend_v = 1'b1;
            end else begin
                nxt_s.code = code_wr.code; // [RQ2]
                nxt_s.mode = MODE_IDLE;
                nxt_s.timer = step_ival(s_ff.cfg.gen, s_ff.up) - dfc_cnt_t'(1); // [RQ17]
            end
        end else if (ld_go) begin
            nxt_s.code = s_ff.pend; // [RQ3]
            nxt_s.pend_v = 1'b0;
            nxt_s.mode = MODE_IDLE;
        end else if (mgo) begin
            nxt_s.target = margin_req.high ? upper_bound_code : lower_bound_code;
            nxt_s.up = margin_req.high;
            nxt_s.timer = step_ival(s_ff.cfg.gen, margin_req.high) - dfc_cnt_t'(1);
            if (!s_ff.cfg.gen.log_en && s_ff.cfg.gen.lo == SLEW_NONE) begin
                nxt_s.code = nxt_s.target; // [RQ9]
                nxt_s.mode = MODE_IDLE;
            end else begin
                nxt_s.mode = MODE_MARGIN; // [RQ7]
                if (s_ff.cfg.gen.log_en && margin_req.high && s_ff.code == ZERO_CODE) begin
                    nxt_s.code = ONE_CODE; // [RQ14]
                end
            end
        end else if (step) begin
            unique case (s_ff.mode)
                MODE_IDLE: begin
                end
                MODE_MARGIN: begin
                    if (s_ff.cfg.gen.log_en) begin
                        nxt_s.code = s_ff.up
                            ? sat_up(s_ff.code, log_amt(s_ff.code), s_ff.target) // [RQ12]
                            : sat_dn(s_ff.code, log_amt(s_ff.code), s_ff.target); // [RQ13]
                    end else begin
                        nxt_s.code = s_ff.up
                            ? sat_up(s_ff.code, lin_amt(s_ff.cfg.gen.hi), s_ff.target)
                            : sat_dn(s_ff.code, lin_amt(s_ff.cfg.gen.hi), s_ff.target); // [RQ8]
                    end
                    if (nxt_s.code == s_ff.target) begin
                        nxt_s.mode = MODE_IDLE; // [RQ11]
                    end
                end
                MODE_WAVE: begin
                    // Sine follows the triangle path; no table in this channel
                    if (s_ff.cfg.gen.wave == WAVE_SAW) begin
                        nxt_s.code = (s_ff.code >= upper_bound_code) ? lower_bound_code
                            : sat_up(s_ff.code, lin_amt(s_ff.cfg.gen.hi), upper_bound_code);
                    end else if (s_ff.cfg.gen.wave == WAVE_INV) begin
                        nxt_s.code = (s_ff.code <= lower_bound_code) ? upper_bound_code
                            : sat_dn(s_ff.code, lin_amt(s_ff.cfg.gen.hi), lower_bound_code);
                    end else if (s_ff.up) begin
                        nxt_s.code = sat_up(s_ff.code, lin_amt(s_ff.cfg.gen.hi),
                                            upper_bound_code);
                        nxt_s.up = (nxt_s.code != upper_bound_code);
                    end else begin
                        nxt_s.code = sat_dn(s_ff.code, lin_amt(s_ff.cfg.gen.hi),
                                            lower_bound_code);
                        nxt_s.up = (nxt_s.code == lower_bound_code);
                    end
                end
            endcase
        end
        nxt_s.busy = (nxt_s.mode != MODE_IDLE);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
            s_ff.cfg <= FUNC_SETUP_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign dac_code = s_ff.code;
    assign ramp_busy = s_ff.busy;
    assign reg_rdata = s_ff.rdata;

    clear_level_a: // [RQ1]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        clear_req |=> dac_code == ($past(s_ff.cfg.clr_sel) ? MID_CODE : ZERO_CODE))
    else $error("clear level wrong");

    direct_update_a: // [RQ2]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        acc && !s_ff.cfg.defer |=> dac_code == $past(code_wr.code) && !ramp_busy)
    else $error("immediate write not applied");

    deferred_hold_a: // [RQ3]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        acc && s_ff.cfg.defer |=> dac_code == $past(dac_code) && s_ff.pend_v)
    else $error("deferred write reached output early");

    load_apply_a: // [RQ3]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        ld_go |=> dac_code == $past(s_ff.pend) && !s_ff.pend_v)
    else $error("load did not apply held code");

    group_block_a: // [RQ4]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        code_wr.valid && code_wr.bcast && !s_ff.cfg.group && quiet && !ld_go &&
        !margin_req.go && s_ff.mode == MODE_IDLE
        |=> dac_code == $past(dac_code) && s_ff.pend == $past(s_ff.pend) &&
            s_ff.pend_v == $past(s_ff.pend_v))
    else $error("broadcast taken while blocked");

    phase_zero_a: // [RQ5]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        !clear_req && cfg_wr && wave_on(reg_req.wdata[12:0]) && reg_req.wdata[12:11] == PH_0
        |=> dac_code == $past(lower_bound_code) && ramp_busy)
    else $error("waveform did not start at lower bound");

    wave_off_a: // [RQ6]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        s_ff.cfg.gen.wave == WAVE_OFF |-> s_ff.mode != MODE_WAVE)
    else $error("generator runs while disabled");

    jump_a: // [RQ9]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        mgo && !s_ff.cfg.gen.log_en && s_ff.cfg.gen.lo == SLEW_NONE
        |=> dac_code == ($past(margin_req.high) ? $past(upper_bound_code)
                                         : $past(lower_bound_code)) && !ramp_busy)
    else $error("zero interval did not jump");

    lin_step_a: // [RQ8]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        step && s_ff.mode == MODE_MARGIN && !s_ff.cfg.gen.log_en && s_ff.up &&
        ({1'b0, dac_code} + {1'b0, lin_amt(s_ff.cfg.gen.hi)} < {1'b0, s_ff.target})
        |=> dac_code - $past(dac_code) == $past(lin_amt(s_ff.cfg.gen.hi)))
    else $error("linear step size wrong");

    log_up_a: // [RQ12]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        step && s_ff.mode == MODE_MARGIN && s_ff.cfg.gen.log_en && s_ff.up &&
        ({1'b0, dac_code} + {1'b0, log_amt(dac_code)} < {1'b0, s_ff.target})
        |=> dac_code - $past(dac_code) == $past(log_amt(dac_code)))
    else $error("upward log step wrong");

    log_down_a: // [RQ13]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        step && s_ff.mode == MODE_MARGIN && s_ff.cfg.gen.log_en && !s_ff.up &&
        dac_code > s_ff.target && dac_code - s_ff.target > log_amt(dac_code)
        |=> $past(dac_code) - dac_code == $past(log_amt(dac_code)))
    else $error("downward log step wrong");

    log_start_a: // [RQ14]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        mgo && s_ff.cfg.gen.log_en && margin_req.high && dac_code == ZERO_CODE
        |=> dac_code == ONE_CODE ##1 dac_code != ZERO_CODE)
    else $error("log ramp started from zero");

endmodule // dfc_channel_func

// >>> verification/dfc_host_model.sv
`timescale 1ns/1ps
// Host side model issuing setup writes, code writes and channel controls
module dfc_host_model
    import dfc_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Requests toward the channel
    output dfc_reg_req_s reg_req,
    output dfc_code_wr_s code_wr,
    output logic load_strobe_pin,
    output logic trig_load,
    output logic clear_req,
    output dfc_margin_s margin_req
);
    initial begin
        reg_req = '0;
        code_wr = '0;
        load_strobe_pin = 1'b1;
        trig_load = 1'b0;
        clear_req = 1'b0;
        margin_req = '0;
    end
    task automatic reg_op(input logic rd, input logic [7:0] addr, input logic [15:0] data);
        @(posedge ref_clk);
        reg_req <= '{wr: !rd, rd: rd, addr: addr, wdata: data};
        @(posedge ref_clk);
        // Released bus shows no stale value
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask
    task automatic code(input logic bc, input logic [CODE_W-1:0] c);
        @(posedge ref_clk);
        code_wr <= '{valid: 1'b1, bcast: bc, code: c};
        @(posedge ref_clk);
        code_wr <= '{valid: 1'b0, bcast: !bc, code: ~c};
    endtask
    task automatic pulse(input int which, input logic high);
        @(posedge ref_clk);
        if (which == 0) trig_load <= 1'b1;
        else if (which == 1) clear_req <= 1'b1;
        else margin_req <= '{go: 1'b1, high: high};
        @(posedge ref_clk);
        trig_load <= 1'b0;
        clear_req <= 1'b0;
        margin_req <= '{go: 1'b0, high: !high};
    endtask
    task automatic pin_fall();
        @(posedge ref_clk);
        load_strobe_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        load_strobe_pin <= 1'b1;
    endtask
endmodule // dfc_host_model

// >>> verification/test_dfc_channel_func.sv
`timescale 1ns/1ps
// Self-checking bench for the channel function setup block
module test_dfc_channel_func
    import dfc_pkg::*;
;
    typedef struct packed {logic [9:0] code; logic [7:0] gap;} dfc_note_s;
    // Short distinct step intervals keep the run brief
    localparam dfc_lin_t LIN = '{3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18};
    localparam dfc_log_t LOG = '{3, 5, 7, 9, 11, 13, 15, 17};
    localparam int INC [8] = '{1, 2, 3, 4, 6, 8, 16, 32};
    localparam int OFF [4] = '{0, 64, 128, 48};
    logic ref_clk, nrst, load_strobe_pin, trig_load, clear_req, ramp_busy, rd_d;
    logic [CODE_W-1:0] lo_b, hi_b, dac_code, last_code, cur, v;
    logic [15:0] reg_rdata;
    logic [31:0] seed;
    dfc_reg_req_s reg_req;
    dfc_code_wr_s code_wr;
    dfc_margin_s margin_req;
    dfc_note_s cq[$];
    logic [15:0] rq[$];
    int err_count, check_count, gap_cnt, st, n;

    dfc_host_model i_dfc_host_model (.ref_clk(ref_clk), .reg_req(reg_req), .code_wr(code_wr),
        .load_strobe_pin(load_strobe_pin), .trig_load(trig_load), .clear_req(clear_req),
        .margin_req(margin_req));
    dfc_channel_func #(.LIN_CYC(LIN), .LOG_CYC(LOG)) i_dfc_channel_func (.ref_clk(ref_clk),
        .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata), .code_wr(code_wr),
        .load_strobe_pin(load_strobe_pin), .trig_load(trig_load), .clear_req(clear_req),
        .margin_req(margin_req), .lower_bound_code(lo_b), .upper_bound_code(hi_b),
        .dac_code(dac_code), .ramp_busy(ramp_busy));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        if (err_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic nt(input logic [9:0] c, input int g);
        cq.push_back('{code: c, gap: g[7:0]});
    endtask
    task automatic setcfg(input logic [2:0] top, input logic [12:0] gen);
        i_dfc_host_model.reg_op(1'b0, FUNC_SETUP_ADDR, {top, gen});
    endtask
    task automatic drain();
        int i;
        i = 0;
        while ((cq.size() != 0 || rq.size() != 0) && i < 3000) begin
            @(posedge ref_clk);
            i++;
        end
        if (i == 3000) begin
            err_count++;
            $display("[ERR] %0t wait ran out", $time);
            test_done();
        end
        repeat (3) @(posedge ref_clk);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Watcher: each read result consumes the oldest expected read, each output change the oldest note
    always @(posedge ref_clk) begin
        dfc_note_s m;
        #1;
        gap_cnt = gap_cnt + 1;
        if (rd_d) begin
            if (rq.size() == 0) chk(16'h0001, 16'h0000);
            else chk(reg_rdata, rq.pop_front());
        end
        rd_d = reg_req.rd;
        if (dac_code !== last_code) begin
            if (cq.size() == 0) chk(16'h0001, 16'h0000);
            else begin
                m = cq.pop_front();
                chk({6'h00, dac_code}, {6'h00, m.code});
                if (m.gap != 8'h00) chk(16'(gap_cnt), {8'h00, m.gap});
            end
            last_code = dac_code;
            gap_cnt = 0;
        end
        // Margin moves are timed from the go pulse, not from the last change
        if (margin_req.go) gap_cnt = 0;
    end

    initial begin
        nrst = 1'b0;
        lo_b = 10'h100;
        hi_b = 10'h128;
        rd_d = 1'b0;
        last_code = 10'h000;
        cur = 10'h000;
        seed = 32'h99ED;
        err_count = 0;
        check_count = 0;
        gap_cnt = 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        rq.push_back(FUNC_SETUP_RST);
        i_dfc_host_model.reg_op(1'b1, FUNC_SETUP_ADDR, 16'h0000);
        i_dfc_host_model.reg_op(1'b0, 8'h13, 16'hFFFF);
        rq.push_back(16'h0000);
        i_dfc_host_model.reg_op(1'b1, 8'h13, 16'h0000);
        rq.push_back(16'h0000);
        i_dfc_host_model.reg_op(1'b1, FUNC_SETUP_ADDR, 16'h0000);
        setcfg(3'b111, 13'h1FFF);
        rq.push_back(16'hFFFF);
        i_dfc_host_model.reg_op(1'b1, FUNC_SETUP_ADDR, 16'h0000);
        setcfg(3'b000, {2'b00, WAVE_OFF, 8'h00});
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            v = {2'b00, seed[7:1], 1'b1};
            if (v == cur) v ^= 10'h002;
            cur = v;
            nt(v, 0);
            i_dfc_host_model.code(1'b0, v);
        end
        i_dfc_host_model.code(1'b1, cur ^ 10'h300);
        drain();
        setcfg(3'b001, {2'b00, WAVE_OFF, 8'h00});
        nt(cur ^ 10'h300, 0);
        i_dfc_host_model.code(1'b1, cur ^ 10'h300);
        setcfg(3'b011, {2'b00, WAVE_OFF, 8'h00});
        i_dfc_host_model.code(1'b0, cur);
        drain();
        nt(cur, 0);
        i_dfc_host_model.pulse(0, 1'b0);
        i_dfc_host_model.code(1'b0, 10'h2AA);
        drain();
        nt(10'h2AA, 0);
        i_dfc_host_model.pin_fall();
        drain();
        for (int s = 0; s < 2; s++) begin
            setcfg({s[0], 2'b00}, {2'b00, WAVE_OFF, 8'h00});
            nt(10'h155, 0);
            i_dfc_host_model.code(1'b0, 10'h155);
            nt(s ? MID_CODE : ZERO_CODE, 0);
            i_dfc_host_model.pulse(1, 1'b0);
            drain();
        end
        for (int s = 0; s < 8; s++) begin
            setcfg(3'b000, {2'b00, WAVE_OFF, 1'b0, s[2:0], 4'(s + 1)});
            nt(lo_b, 0);
            i_dfc_host_model.code(1'b0, lo_b);
            v = lo_b;
            n = 0;
            while (v < hi_b) begin
                v = (v + INC[s] > hi_b) ? hi_b : v + 10'(INC[s]);
                nt(v, n ? int'(LIN[s + 1]) : 0);
                n++;
            end
            i_dfc_host_model.pulse(2, 1'b1);
            drain();
        end
        setcfg(3'b000, {2'b00, WAVE_OFF, 8'h00});
        nt(lo_b, 1);
        i_dfc_host_model.pulse(2, 1'b0);
        drain();
        lo_b <= 10'h000;
        hi_b <= 10'h040;
        setcfg(3'b000, {2'b00, WAVE_OFF, 1'b1, 3'd2, 3'd5, 1'b0});
        nt(ZERO_CODE, 0);
        i_dfc_host_model.pulse(1, 1'b0);
        nt(ONE_CODE, 0);
        v = ONE_CODE;
        n = 0;
        while (v < 10'h040) begin
            st = (v >> 5) > 0 ? int'(v >> 5) : 1;
            v = (v + st > 10'h040) ? 10'h040 : v + 10'(st);
            nt(v, n ? int'(LOG[2]) : 0);
            n++;
        end
        i_dfc_host_model.pulse(2, 1'b1);
        drain();
        n = 0;
        while (v > 10'h000) begin
            st = (v >> 5) > 0 ? int'(v >> 5) : 1;
            v = (v < st) ? 10'h000 : v - 10'(st);
            nt(v, n ? int'(LOG[5]) : 0);
            n++;
        end
        i_dfc_host_model.pulse(2, 1'b0);
        drain();
        lo_b <= 10'h100;
        hi_b <= 10'h1C0;
        nt(10'h3FF, 0);
        i_dfc_host_model.code(1'b0, 10'h3FF);
        for (int w = 0; w < 8; w++) begin
            for (int p = 0; p < 4; p++) begin
                st = (w == 0 || w == 1 || w == 2 || w == 4);
                if (st) nt(10'h100 + 10'(OFF[p]), 0);
                // A nonzero interval: zero is not legal for waveforms
                setcfg(3'b000, {p[1:0], w[2:0], 1'b0, 3'd0, 4'hF});
                @(posedge ref_clk);
                #1;
                chk({15'h0000, ramp_busy}, 16'(st));
                if (st) begin
                    nt(10'h3FF, 0);
                    i_dfc_host_model.code(1'b0, 10'h3FF);
                end
                drain();
            end
        end
        // Sawtooth stepping: 2 LSB every LIN[1] cycles, wrapping at the upper bound
        hi_b <= 10'h106;
        nt(10'h100, 0);
        setcfg(3'b000, {PH_0, WAVE_SAW, 1'b0, 3'd1, 4'h1});
        for (int k = 1; k < 5; k++) nt(10'h100 + 10'(2 * (k % 4)), int'(LIN[1]));
        repeat (15) @(posedge ref_clk);
        nt(10'h3FF, 1);
        i_dfc_host_model.code(1'b0, 10'h3FF);
        drain();
        test_done();
    end
endmodule // test_dfc_channel_func
